//--- hw/dma_chan_pkg.sv
// constants shared by the dma channel register block and its testbench
// assumes a single 20 MHz clock domain and an apb master with 32-bit data
package dma_chan_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] PRIMARY_START_OFS = 8'h00;
   localparam logic [7:0] SECONDARY_START_OFS = 8'h04;
   localparam logic [7:0] PERIPH_ADDR_OFS = 8'h08;
   localparam logic [7:0] TRANSFER_COUNT_OFS = 8'h0C;
   localparam logic [7:0] CONTROL_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   // field widths and positions
   localparam int ADDR_W = 16;
   localparam int COUNT_W = 10;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SELECT_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_PENDING_BIT = 2;
   localparam int STAT_REMAIN_LSB = 16;
   // reset values
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [9:0] COUNT_RESET = 10'h000;
   // ram pointer advance per transfer, one 16-bit word in byte addresses
   localparam logic [15:0] ADDR_STEP = 16'h0002;
   // width of one transfer descriptor pushed into the buffer
   localparam int XFER_W = 2 * ADDR_W;
   // channel engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACTIVE = 2'b10
   } chan_state_e;
endpackage

//--- hw/dma_channel_regs.sv
// one dma channel: address and count registers on apb plus the transfer engine
// assumes apb master per protocol, peripheral request pulses synchronous to clock
//
// Behaviour
// - channel holds sixteen-bit secondary ram start address
// - secondary register read returns live ram pointer
// - channel holds sixteen-bit peripheral data address
// - ten-bit count; count plus one transfers
// - count upper six bits ignore writes, read zero
// - channel holds sixteen-bit primary ram start address
//
// The implementer's own choices: the register offsets and register access over APB.
module dma_channel_regs (
   input wire logic clock, // 20 MHz system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high for write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic xferReq, // peripheral asks for one transfer
   output logic xferValid, // transfer descriptor available
   output logic [dma_chan_pkg::ADDR_W-1:0] xferRamAddr, // ram address of this transfer
   output logic [dma_chan_pkg::ADDR_W-1:0] xferPeriphAddr, // peripheral address of this transfer
   input wire logic xferReady, // mover takes the descriptor
   output logic channelBusy, // channel enabled and running
   output logic blockDone // one-cycle pulse at block end
);
   import dma_chan_pkg::*;

   logic [ADDR_W-1:0] primaryStart_reg; // primary_start_addr
   logic [ADDR_W-1:0] secondaryStart_reg; // secondary_start_addr
   logic [ADDR_W-1:0] periphAddr_reg; // peripheral_address
   logic [COUNT_W-1:0] transferCount_reg; // transfer_total_minus_one
   logic enable_reg; // channel enable
   logic bufSelect_reg; // 0 primary base, 1 secondary base
   logic done_reg; // sticky block complete
   logic pending_reg; // request waiting for buffer room
   logic [ADDR_W-1:0] ramPtr_reg; // live ram address pointer
   logic [COUNT_W-1:0] remain_reg; // transfers left minus one
   logic [31:0] prdata_reg; // read data latched in setup
   logic pready_reg; // ready for the access phase
   logic pslverr_reg; // error for the access phase
   logic blockDone_reg; // completion pulse
   chan_state_e state_reg; // engine state
   logic [31:0] readMux; // read data for the current address
   logic mapped; // address hits a register
   logic wrStrobe; // write takes effect this edge
   logic startReq; // software enables an idle channel
   logic stopReq; // software disables the channel
   logic doneClear; // software clears the done flag
   logic push; // one transfer enters the buffer
   logic lastPush; // this push ends the block
   logic bufInReady; // buffer room
   logic [XFER_W-1:0] bufOutData; // descriptor leaving the buffer

   // apb strobes: writes land only when the access phase is answered
   assign wrStrobe = psel && penable && pready_reg && pwrite;
   assign startReq = wrStrobe && (paddr == CONTROL_OFS) && pwdata[CTRL_ENABLE_BIT] && !enable_reg;
   assign stopReq = wrStrobe && (paddr == CONTROL_OFS) && !pwdata[CTRL_ENABLE_BIT];
   assign doneClear = wrStrobe && (paddr == STATUS_OFS) && pwdata[STAT_DONE_BIT];
   assign push = (state_reg == ST_ACTIVE) && (pending_reg || xferReq) && bufInReady;
   assign lastPush = push && (remain_reg == COUNT_RESET);

   // read decode; both start address registers show the live pointer
   always_comb begin
      readMux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         PRIMARY_START_OFS: readMux[ADDR_W-1:0] = ramPtr_reg;
         SECONDARY_START_OFS: readMux[ADDR_W-1:0] = ramPtr_reg;
         PERIPH_ADDR_OFS: readMux[ADDR_W-1:0] = periphAddr_reg;
         TRANSFER_COUNT_OFS: readMux[COUNT_W-1:0] = transferCount_reg;
         CONTROL_OFS: begin
            readMux[CTRL_ENABLE_BIT] = enable_reg;
            readMux[CTRL_SELECT_BIT] = bufSelect_reg;
         end
         STATUS_OFS: begin
            readMux[STAT_BUSY_BIT] = enable_reg;
            readMux[STAT_DONE_BIT] = done_reg;
            readMux[STAT_PENDING_BIT] = pending_reg;
            readMux[STAT_REMAIN_LSB +: COUNT_W] = remain_reg;
         end
         default: mapped = 1'b0;
      endcase
   end

   // apb answer: one wait-free access phase, data captured in setup
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata_reg <= readMux;
         end
      end
   end

   // configuration registers; writes while enabled are the caller's risk
   always_ff @(posedge clock) begin
      if (!nrst) begin
         primaryStart_reg <= ADDR_RESET;
         secondaryStart_reg <= ADDR_RESET;
         periphAddr_reg <= ADDR_RESET;
         transferCount_reg <= COUNT_RESET;
         bufSelect_reg <= 1'b0;
      end else if (wrStrobe) begin
         case (paddr)
            PRIMARY_START_OFS: primaryStart_reg <= pwdata[ADDR_W-1:0];
            SECONDARY_START_OFS: secondaryStart_reg <= pwdata[ADDR_W-1:0];
            PERIPH_ADDR_OFS: periphAddr_reg <= pwdata[ADDR_W-1:0];
            TRANSFER_COUNT_OFS: transferCount_reg <= pwdata[COUNT_W-1:0];
            CONTROL_OFS: bufSelect_reg <= pwdata[CTRL_SELECT_BIT];
            default: bufSelect_reg <= bufSelect_reg;
         endcase
      end
   end

   // engine state, enable, pointer and remaining count
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         enable_reg <= 1'b0;
         ramPtr_reg <= ADDR_RESET;
         remain_reg <= COUNT_RESET;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (startReq) begin
                  // base chosen by the select bit written in the same word
                  ramPtr_reg <= pwdata[CTRL_SELECT_BIT] ? secondaryStart_reg : primaryStart_reg;
                  remain_reg <= transferCount_reg;
                  enable_reg <= 1'b1;
                  state_reg <= ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (stopReq || lastPush) begin
                  // block ends after count plus one pushes
                  enable_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
               if (push) begin
                  ramPtr_reg <= ramPtr_reg + ADDR_STEP;
                  if (!lastPush) begin
                     remain_reg <= remain_reg - 10'h001;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // request latch: a request meeting a full buffer waits; a new one wins over the clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pending_reg <= 1'b0;
      end else if (state_reg != ST_ACTIVE || stopReq) begin
         pending_reg <= 1'b0;
      end else if (xferReq && !(push && !pending_reg)) begin
         pending_reg <= 1'b1;
      end else if (push) begin
         pending_reg <= 1'b0;
      end
   end

   // done flag and pulse; completion beats a simultaneous software clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         done_reg <= 1'b0;
         blockDone_reg <= 1'b0;
      end else begin
         blockDone_reg <= lastPush && !stopReq;
         if (lastPush && !stopReq) begin
            done_reg <= 1'b1;
         end else if (doneClear) begin
            done_reg <= 1'b0;
         end
      end
   end

   // descriptor buffer; its ready stalls the engine, so a slow mover loses nothing
   two_entry_buffer #(.WIDTH(XFER_W)) descBuf (
      .clock(clock),
      .nrst(nrst),
      .inValid(push),
      .inData({ramPtr_reg, periphAddr_reg}),
      .inReady(bufInReady),
      .outValid(xferValid),
      .outData(bufOutData),
      .outReady(xferReady)
   );

   assign xferRamAddr = bufOutData[XFER_W-1:ADDR_W];
   assign xferPeriphAddr = bufOutData[ADDR_W-1:0];
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign channelBusy = enable_reg;
   assign blockDone = blockDone_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_setupRead(logic [7:0] ofs);
      psel && !penable && !pwrite && paddr == ofs;
   endsequence

   sequence s_writeTo(logic [7:0] ofs);
      wrStrobe && paddr == ofs;
   endsequence

   a_secondary_reads_ptr: assert property (s_setupRead(SECONDARY_START_OFS) |=>
      pready && prdata == {16'h0000, $past(ramPtr_reg)})
      else $error("secondary start read did not return the live pointer");

   a_count_upper_zero: assert property (s_setupRead(TRANSFER_COUNT_OFS) |=>
      prdata[31:COUNT_W] == 22'h00_0000 && prdata[COUNT_W-1:0] == transferCount_reg)
      else $error("transfer count read shows upper bits or wrong value");

   a_count_write_masked: assert property (s_writeTo(TRANSFER_COUNT_OFS) |=>
      transferCount_reg == $past(pwdata[COUNT_W-1:0]))
      else $error("transfer count write not stored in ten bits");

   a_secondary_write_held: assert property (s_writeTo(SECONDARY_START_OFS) |=>
      secondaryStart_reg == $past(pwdata[15:0]) ##1 secondaryStart_reg == $past(pwdata[15:0], 2))
      else $error("secondary start address not held");

   a_primary_write_held: assert property (s_writeTo(PRIMARY_START_OFS) |=>
      primaryStart_reg == $past(pwdata[15:0]))
      else $error("primary start address not stored");

   a_periph_write_held: assert property (s_writeTo(PERIPH_ADDR_OFS) |=>
      periphAddr_reg == $past(pwdata[15:0]))
      else $error("peripheral address not stored");

   a_block_end_count: assert property (lastPush && !stopReq |=>
      !channelBusy && blockDone && done_reg ##1 !blockDone)
      else $error("block did not end after count plus one transfers");

   a_push_advances_ptr: assert property (push && !lastPush |=>
      ramPtr_reg == $past(ramPtr_reg) + ADDR_STEP && remain_reg == $past(remain_reg) - 10'h001)
      else $error("transfer did not advance pointer and count");

   a_reset_clears_all: assert property (disable iff (1'b0) !nrst |=>
      primaryStart_reg == 16'h0000 && secondaryStart_reg == 16'h0000 && periphAddr_reg == 16'h0000
      && transferCount_reg == 10'h000 && !channelBusy && !xferValid && !pready)
      else $error("registers not cleared by reset");
endmodule

//--- hw/two_entry_buffer.sv
// two-entry skid buffer with valid and ready on both sides
// assumes the filling side holds data while inValid is high and inReady low
module two_entry_buffer #(
   parameter int WIDTH = 32
) (
   input wire logic clock, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic inValid, // filling side offers a word
   input wire logic [WIDTH-1:0] inData, // word offered
   output logic inReady, // buffer can take a word
   output logic outValid, // head word valid
   output logic [WIDTH-1:0] outData, // head word
   input wire logic outReady // draining side takes the head word
);
   logic skidValid_reg; // second entry occupied
   logic [WIDTH-1:0] skidData_reg; // second entry
   logic outValid_reg; // head entry occupied
   logic [WIDTH-1:0] outData_reg; // head entry
   logic inReady_reg; // mirror of an empty second entry

   assign outValid = outValid_reg;
   assign outData = outData_reg;
   assign inReady = inReady_reg;

   // head and skid update; skid only fills when the head is stalled, so nothing is lost
   always_ff @(posedge clock) begin
      if (!nrst) begin
         outValid_reg <= 1'b0;
         outData_reg <= '0;
         skidValid_reg <= 1'b0;
         skidData_reg <= '0;
         inReady_reg <= 1'b1;
      end else if (!outValid_reg || outReady) begin
         // head is free or leaving: refill from skid first to keep order
         if (skidValid_reg) begin
            outData_reg <= skidData_reg;
            outValid_reg <= 1'b1;
            skidValid_reg <= 1'b0;
            inReady_reg <= 1'b1;
         end else if (inValid) begin
            outData_reg <= inData;
            outValid_reg <= 1'b1;
         end else begin
            outValid_reg <= 1'b0;
         end
      end else if (inValid && inReady_reg) begin
         // head stalled: park the word and stop the source
         skidData_reg <= inData;
         skidValid_reg <= 1'b1;
         inReady_reg <= 1'b0;
      end
   end
endmodule

//--- testbench/dma_channel_regs_test.sv
// self-checking bench for the channel address and count registers and their engine
// assumes the package offsets are byte addresses; the master waits for pready however long it takes
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin errCount++; \
   $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module dma_channel_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dma_chan_pkg::*;
   logic clock, nrst, psel, penable, pwrite, pready, pslverr; // clock, reset and apb
   logic [7:0] paddr; // apb byte address
   logic [31:0] pwdata, prdata; // apb data
   logic xferReq, xferValid, xferReady, channelBusy, blockDone; // stream and status
   logic [ADDR_W-1:0] xferRamAddr, xferPeriphAddr; // head descriptor
   logic run, stall; // partner controls
   logic [31:0] got[$]; // descriptors taken by the mover
   int errCount, nTests, doneCount, cycles; // bookkeeping

   dma_channel_regs DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xferReq(xferReq), .xferValid(xferValid), .xferRamAddr(xferRamAddr),
      .xferPeriphAddr(xferPeriphAddr), .xferReady(xferReady), .channelBusy(channelBusy),
      .blockDone(blockDone));
   periph_model partner (.clock(clock), .nrst(nrst), .run(run), .stall(stall), .xferReq(xferReq),
      .xferReady(xferReady));

   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // record every accepted descriptor and block end; a hang is cut short here
   always @(posedge clock) begin
      cycles++;
      if (nrst === 1'b1 && xferValid === 1'b1 && xferReady === 1'b1) got.push_back({xferRamAddr, xferPeriphAddr});
      if (blockDone === 1'b1) doneCount++;
      if (cycles == 5000) begin
         errCount++;
         results();
      end
   end

   // one apb transfer; request held until the edge where pready is sampled high, released right after it
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // no wait count is assumed; only the bench timeout ends a hang here
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      // answer taken at the same edge that samples pready high, then the request is dropped
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read and compare data and error response
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0000_0000, r, e);
      `CHK("read data", exp, r)
      `CHK("read error", expErr, e)
   endtask

   // write, ignoring the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask

   // address and count registers start at zero and the channel is idle
   task automatic testReset();
      rdChk(PRIMARY_START_OFS, 32'h0000_0000, 1'b0);
      rdChk(SECONDARY_START_OFS, 32'h0000_0000, 1'b0);
      rdChk(PERIPH_ADDR_OFS, 32'h0000_0000, 1'b0);
      rdChk(TRANSFER_COUNT_OFS, 32'h0000_0000, 1'b0);
      `CHK("busy after reset", 1'b0, channelBusy)
      $display("test reset done");
   endtask

   // field widths, unimplemented count bits, live pointer on read, unmapped place
   task automatic testFields();
      wr(PERIPH_ADDR_OFS, 32'hFFFF_A5C3);
      rdChk(PERIPH_ADDR_OFS, 32'h0000_A5C3, 1'b0);
      wr(TRANSFER_COUNT_OFS, 32'hFFFF_FFFF);
      rdChk(TRANSFER_COUNT_OFS, 32'h0000_03FF, 1'b0);
      wr(SECONDARY_START_OFS, 32'h0000_1234);
      // idle pointer still shows zero, not the value just written
      rdChk(SECONDARY_START_OFS, 32'h0000_0000, 1'b0);
      wr(8'h20, 32'h0000_5555);
      rdChk(8'h20, 32'h0000_0000, 1'b1);
      $display("test fields done");
   endtask

   // one block: count+1 descriptors stepping by two from the chosen base
   task automatic testBlock(input logic sel, input logic [9:0] lastIdx, input logic stalled);
      logic [15:0] base;
      base = sel ? 16'h1234 : 16'h0100;
      // registers are set only while the channel is idle
      wr(PRIMARY_START_OFS, 32'h0000_0100);
      wr(SECONDARY_START_OFS, 32'h0000_1234);
      wr(PERIPH_ADDR_OFS, 32'h0000_A5C3);
      wr(TRANSFER_COUNT_OFS, {22'h00_0000, lastIdx});
      got.delete();
      doneCount = 0;
      wr(CONTROL_OFS, {30'h0000_0000, sel, 1'b1});
      rdChk(sel ? SECONDARY_START_OFS : PRIMARY_START_OFS, {16'h0000, base}, 1'b0);
      `CHK("busy after start", 1'b1, channelBusy)
      run <= 1'b1;
      stall <= stalled;
      // a block that never ends is caught by the bench timeout
      while (doneCount == 0) begin
         @(posedge clock);
      end
      @(posedge clock);
      run <= 1'b0;
      stall <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK("done pulses", 1, doneCount)
      `CHK("transfers", int'(lastIdx) + 1, got.size())
      `CHK("busy after end", 1'b0, channelBusy)
      foreach (got[i]) `CHK("descriptor", {base + 16'(2 * i), 16'hA5C3}, got[i])
      $display("test block done");
   endtask

   // sticky done flag and its clear, then a software stop that must not signal completion
   task automatic testStop();
      rdChk(STATUS_OFS, 32'h0000_0002, 1'b0);
      wr(STATUS_OFS, 32'h0000_0002);
      rdChk(STATUS_OFS, 32'h0000_0000, 1'b0);
      doneCount = 0;
      // no requests while run is low, so the loaded remaining count stays put
      wr(CONTROL_OFS, 32'h0000_0001);
      rdChk(STATUS_OFS, 32'h0007_0001, 1'b0);
      wr(CONTROL_OFS, 32'h0000_0000);
      rdChk(CONTROL_OFS, 32'h0000_0000, 1'b0);
      `CHK("busy after stop", 1'b0, channelBusy)
      `CHK("done pulses after stop", 0, doneCount)
      $display("test stop done");
   endtask

   // counts and verdict, then end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence
   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, run, stall} = 5'b0_0000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      errCount = 0;
      nTests = 0;
      doneCount = 0;
      cycles = 0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      testReset();
      testFields();
      testBlock(1'b1, 10'h002, 1'b1);
      testBlock(1'b0, 10'h000, 1'b0);
      testBlock(1'b1, 10'h007, 1'b0);
      testStop();
      results();
   end
endmodule

//--- testbench/periph_model.sv
// behavioural peripheral on the far side of the channel's transfer stream
// assumes the same clock and reset as the channel; all outputs change by nba on the rising edge
module periph_model (
   input wire logic clock, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic run, // bench lets the peripheral ask for transfers
   input wire logic stall, // bench asks the mover to hold off now and then
   output logic xferReq, // one-cycle transfer request
   output logic xferReady // mover takes the head descriptor
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase; // free-running slot counter

   // request every fourth cycle; a slow peripheral, so the buffer never fills, even when stalled
   always_ff @(posedge clock) begin
      if (!nrst) begin
         phase <= 2'h0;
         xferReq <= 1'b0;
         xferReady <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         xferReq <= run && (phase == 2'h0);
         // stalled mover accepts only in half of the slots
         xferReady <= stall ? phase[1] : 1'b1;
      end
   end
endmodule
